/* src/pmi_pkg.sv */
// shared constants and types for the proximity measure and interrupt controller
package pmi_pkg;

  // ==========================================================================
  // timing: figures in their own units, cycle counts derived from the clock
  localparam int CLK_PERIOD_NS   = 5;
  localparam int PULSE_PERIOD_NS = 16000;
  localparam int PULSE_ON_NS     = 7200;
  localparam int STEP_TIME_NS    = 2730000;
  localparam int WAIT_STEP_NS    = 2730000;
  localparam int PULSE_PERIOD_CYC = PULSE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PULSE_ON_CYC     = PULSE_ON_NS / CLK_PERIOD_NS;
  localparam int STEP_CYC_DEF     = STEP_TIME_NS / CLK_PERIOD_NS;
  localparam int WAIT_CYC_DEF     = WAIT_STEP_NS / CLK_PERIOD_NS;
  localparam int STEP_CNT_W       = 20;
  localparam logic [9:0] STEP_MAX_COUNT = 10'h3ff;

  // ==========================================================================
  // register byte offsets
  localparam logic [5:0] OFS_ENABLE    = 6'h00;
  localparam logic [5:0] OFS_CONV_STEP = 6'h04;
  localparam logic [5:0] OFS_WAIT_STEP = 6'h08;
  localparam logic [5:0] OFS_LOW_THR   = 6'h0c;
  localparam logic [5:0] OFS_HIGH_THR  = 6'h10;
  localparam logic [5:0] OFS_PERSIST   = 6'h14;
  localparam logic [5:0] OFS_LED_CFG   = 6'h18;
  localparam logic [5:0] OFS_OFFSET    = 6'h1c;
  localparam logic [5:0] OFS_STATUS    = 6'h20;
  localparam logic [5:0] OFS_DATA      = 6'h24;
  localparam logic [5:0] OFS_COMMAND   = 6'h28;
  localparam logic [5:0] OFS_EV_STATUS = 6'h2c;
  localparam logic [5:0] OFS_EV_MASK   = 6'h30;

  // ==========================================================================
  // field positions and reset values
  localparam int LED_DRIVE_LSB = 8;
  localparam int CMD_CLEAR_BIT = 0;
  localparam int STAT_VALID    = 0;
  localparam int STAT_IRQ      = 1;
  localparam int STAT_SAT      = 2;
  localparam int EV_DONE       = 0;
  localparam int EV_FIRE       = 1;
  localparam int EV_SAT        = 2;
  localparam logic [7:0] CONV_STEP_RST = 8'hff;
  localparam logic [7:0] WAIT_STEP_RST = 8'hff;
  localparam logic [7:0] PULSE_CNT_RST = 8'h01;

  // enable register, bit 0 is power_on_bit
  typedef struct packed {
    logic sleep_after_irq;
    logic prox_irq_output_enable;
    logic wait_enable;
    logic prox_function_enable;
    logic power_on_bit;
  } pmi_ctrl_t;

  typedef struct packed {
    logic [1:0] led_drive_level;
    logic [7:0] led_pulse_count;
  } pmi_led_t;

  typedef enum logic [2:0] {
    ST_SLEEP = 3'b000,
    ST_IDLE  = 3'b001,
    ST_PULSE = 3'b010,
    ST_CONV  = 3'b011,
    ST_EVAL  = 3'b100,
    ST_WAIT  = 3'b101
  } pmi_state_t;

endpackage

/* src/pmi_sync2.sv */
// two-flop synchroniser for signals from outside the clock domain
`timescale 1ns/10ps
module pmi_sync2
  import pmi_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;

  // ==========================================================================
  // first stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else if (ce)
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

/* src/pmi_step_timer.sv */
// counts a number of fixed-length steps, pulsing at each step end
`timescale 1ns/10ps
module pmi_step_timer
  import pmi_pkg::*;
#(
  parameter int STEP_CYC = STEP_CYC_DEF
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  input  wire logic       start,
  input  wire logic [8:0] steps,
  output logic            step_tick,
  output logic            done
);

  logic [STEP_CNT_W-1:0] cyc_reg;
  logic [8:0]            left_reg;
  logic                  busy_reg;
  wire                   step_end = busy_reg && (cyc_reg == STEP_CNT_W'(STEP_CYC - 1));

  // ==========================================================================
  // start restarts the count; a step of zero steps is not possible (min 1)
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cyc_reg   <= '0;
      left_reg  <= '0;
      busy_reg  <= 1'b0;
      step_tick <= 1'b0;
      done      <= 1'b0;
    end
    else if (ce)
    begin
      step_tick <= step_end;
      done      <= step_end && (left_reg == 9'h001);
      if (start)
      begin
        cyc_reg  <= '0;
        left_reg <= steps;
        busy_reg <= 1'b1;
      end
      else if (step_end)
      begin
        cyc_reg  <= '0;
        left_reg <= left_reg - 9'h001;
        busy_reg <= (left_reg != 9'h001);
      end
      else if (busy_reg)
        cyc_reg <= cyc_reg + STEP_CNT_W'(1);
    end
  end

endmodule

/* src/pmi_top.sv */
// proximity measure sequencer, threshold interrupt and register slave
//
// Chosen here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module pmi_top
  import pmi_pkg::*;
#(
  parameter int STEP_CYC = STEP_CYC_DEF,
  parameter int WAIT_CYC = WAIT_CYC_DEF
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq,
  input  wire logic        bus_scl,
  input  wire logic        bus_sda,
  input  wire logic [9:0]  afe_step_count,
  input  wire logic        afe_saturated,
  output logic             led_sink_driver_pin,
  output logic      [1:0]  led_drive_level,
  output logic             int_pin_out,
  output logic             int_pin_oe
);

  // ==========================================================================
  // registers and state
  pmi_ctrl_t   ctrl_reg;
  pmi_led_t    led_reg;
  pmi_state_t  state_reg;
  logic [7:0]  conv_step_reg;
  logic [7:0]  wait_step_reg;
  logic [15:0] low_thr_reg;
  logic [15:0] high_thr_reg;
  logic [3:0]  persist_reg;
  logic [8:0]  offset_reg;
  logic [15:0] data_reg;
  logic [15:0] acc_reg;
  logic [3:0]  out_cnt_reg;
  logic [11:0] phase_reg;
  logic [7:0]  pulses_left_reg;
  logic        prox_irq_reg;
  logic        prox_saturation_flag_reg;
  logic        valid_reg;
  logic [2:0]  ev_reg;
  logic [2:0]  mask_reg;
  logic        ack_reg;
  logic        sda_d_reg;

  // ==========================================================================
  // synchronisers for pins and the analog front end
  logic [1:0] bus_s;
  logic [10:0] afe_s;

  pmi_sync2 #(.W(2)) u_bus_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .ce       (ce),
    .async_in ({bus_scl, bus_sda}),
    .sync_out (bus_s)
  );

  pmi_sync2 #(.W(11)) u_afe_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .ce       (ce),
    .async_in ({afe_saturated, afe_step_count}),
    .sync_out (afe_s)
  );

  // ==========================================================================
  // bus decode; each request gets one wait cycle, answered on the second
  wire        req      = (avs_read || avs_write) && !ack_reg;
  wire        wr_take  = avs_write && ack_reg;
  wire        wr_cmd   = wr_take && (avs_address == OFS_COMMAND);
  wire        clr_cmd  = wr_cmd && avs_writedata[CMD_CLEAR_BIT];
  wire        wr_ev    = wr_take && (avs_address == OFS_EV_STATUS);
  wire [2:0]  w1c      = wr_ev ? avs_writedata[2:0] : 3'b000;
  wire        start_c  = bus_s[1] && sda_d_reg && !bus_s[0];
  wire        wake     = start_c || req;

  // ==========================================================================
  // timers for conversion steps and wait steps
  wire        conv_go  = (state_reg == ST_PULSE) && (pulses_left_reg == 8'h00);
  wire [8:0]  conv_n   = 9'h100 - {1'b0, conv_step_reg};
  wire [8:0]  wait_n   = 9'h100 - {1'b0, wait_step_reg};
  logic       conv_tick;
  logic       conv_done;
  logic       wait_done;
  logic       wait_go;

  pmi_step_timer #(.STEP_CYC(STEP_CYC)) u_conv_timer (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .ce        (ce),
    .start     (conv_go),
    .steps     (conv_n),
    .step_tick (conv_tick),
    .done      (conv_done)
  );

  pmi_step_timer #(.STEP_CYC(WAIT_CYC)) u_wait_timer (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .ce        (ce),
    .start     (wait_go),
    .steps     (wait_n),
    .step_tick (),
    .done      (wait_done)
  );

  // ==========================================================================
  // result, window and persistence
  wire signed [17:0] sum_w   = $signed({2'b00, acc_reg}) + $signed({{9{offset_reg[8]}},
                                offset_reg});
  wire [15:0] result_w  = sum_w[17] ? 16'h0000 : (sum_w[16] ? 16'hffff : sum_w[15:0]);
  wire        below_w   = result_w < low_thr_reg;
  wire        above_w   = (low_thr_reg <= high_thr_reg) && (result_w > high_thr_reg);
  wire        outside_w = below_w || above_w;
  wire [4:0]  cnt_inc   = {1'b0, out_cnt_reg} + 5'h01;
  wire        eval      = (state_reg == ST_EVAL);
  wire        fire      = eval && outside_w && (cnt_inc >= {1'b0, persist_reg});
  wire [16:0] acc_sum   = {1'b0, acc_reg} + {7'h00, afe_s[9:0]};
  wire        sat_evt   = (state_reg == ST_PULSE) && afe_s[10];
  wire        led_on    = (state_reg == ST_PULSE) && (pulses_left_reg != 8'h00)
                          && (phase_reg < 12'(PULSE_ON_CYC));
  wire        phase_end = phase_reg == 12'(PULSE_PERIOD_CYC - 1);
  assign wait_go = eval && !(fire && ctrl_reg.sleep_after_irq) && ctrl_reg.wait_enable;

  // ==========================================================================
  // next state of the sequencer
  pmi_state_t state_next;
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_SLEEP: if (wake) state_next = ST_IDLE;
      ST_IDLE:
        if (!ctrl_reg.power_on_bit) state_next = ST_SLEEP;
        else if (ctrl_reg.prox_function_enable) state_next = ST_PULSE;
      ST_PULSE: if (conv_go) state_next = ST_CONV;
      ST_CONV:  if (conv_done) state_next = ST_EVAL;
      ST_EVAL:
        if (fire && ctrl_reg.sleep_after_irq) state_next = ST_SLEEP;
        else if (ctrl_reg.wait_enable) state_next = ST_WAIT;
        else state_next = ST_IDLE;
      ST_WAIT:  if (wait_done) state_next = ST_IDLE;
      default:  state_next = ST_SLEEP;
    endcase
  end

  // ==========================================================================
  // read data selection; unmapped offsets read zero
  wire [31:0] rd_w =
    (avs_address == OFS_ENABLE)    ? {27'h0, ctrl_reg} :
    (avs_address == OFS_CONV_STEP) ? {24'h0, conv_step_reg} :
    (avs_address == OFS_WAIT_STEP) ? {24'h0, wait_step_reg} :
    (avs_address == OFS_LOW_THR)   ? {16'h0, low_thr_reg} :
    (avs_address == OFS_HIGH_THR)  ? {16'h0, high_thr_reg} :
    (avs_address == OFS_PERSIST)   ? {28'h0, persist_reg} :
    (avs_address == OFS_LED_CFG)   ? {22'h0, led_reg} :
    (avs_address == OFS_OFFSET)    ? {23'h0, offset_reg} :
    (avs_address == OFS_STATUS)    ? {26'h0, state_reg, prox_saturation_flag_reg,
                                      prox_irq_reg, valid_reg} :
    (avs_address == OFS_DATA)      ? {16'h0, data_reg} :
    (avs_address == OFS_EV_STATUS) ? {29'h0, ev_reg} :
    (avs_address == OFS_EV_MASK)   ? {29'h0, mask_reg} : 32'h0000_0000;

  // ==========================================================================
  // bus handshake; waitrequest drops in the cycle after the request appears
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ack_reg         <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end
    else if (ce)
    begin
      ack_reg         <= req;
      avs_waitrequest <= !req;
      if (req && avs_read)
        avs_readdata <= rd_w;
    end
  end

  // ==========================================================================
  // software-written configuration
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl_reg      <= '0;
      conv_step_reg <= CONV_STEP_RST;
      wait_step_reg <= WAIT_STEP_RST;
      low_thr_reg   <= 16'h0000;
      high_thr_reg  <= 16'h0000;
      persist_reg   <= 4'h0;
      led_reg       <= '{led_drive_level: 2'b00, led_pulse_count: PULSE_CNT_RST};
      offset_reg    <= 9'h000;
      mask_reg      <= 3'b000;
    end
    else if (ce && wr_take)
    begin
      unique case (avs_address)
        OFS_ENABLE:    ctrl_reg      <= pmi_ctrl_t'(avs_writedata[4:0]);
        OFS_CONV_STEP: conv_step_reg <= avs_writedata[7:0];
        OFS_WAIT_STEP: wait_step_reg <= avs_writedata[7:0];
        OFS_LOW_THR:   low_thr_reg   <= avs_writedata[15:0];
        OFS_HIGH_THR:  high_thr_reg  <= avs_writedata[15:0];
        OFS_PERSIST:   persist_reg   <= avs_writedata[3:0];
        OFS_LED_CFG:   led_reg       <= pmi_led_t'(avs_writedata[9:0]);
        OFS_OFFSET:    offset_reg    <= avs_writedata[8:0];
        OFS_EV_MASK:   mask_reg      <= avs_writedata[2:0];
        default:       mask_reg      <= mask_reg;
      endcase
    end
  end

  // ==========================================================================
  // sequencer, LED burst and accumulation
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_reg       <= ST_SLEEP;
      phase_reg       <= 12'h000;
      pulses_left_reg <= 8'h00;
      acc_reg         <= 16'h0000;
      sda_d_reg       <= 1'b0;
    end
    else if (ce)
    begin
      state_reg <= state_next;
      sda_d_reg <= bus_s[0];
      if (state_reg == ST_IDLE)
      begin
        pulses_left_reg <= led_reg.led_pulse_count;
        phase_reg       <= 12'h000;
        acc_reg         <= 16'h0000;
      end
      else if (state_reg == ST_PULSE && pulses_left_reg != 8'h00)
      begin
        phase_reg <= phase_end ? 12'h000 : phase_reg + 12'h001;
        if (phase_end)
          pulses_left_reg <= pulses_left_reg - 8'h01;
      end
      else if (state_reg == ST_CONV && conv_tick)
        acc_reg <= acc_sum[16] ? 16'hffff : acc_sum[15:0];
    end
  end

  // ==========================================================================
  // result, flags and persistence; a set in the clearing cycle wins
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      data_reg                 <= 16'h0000;
      out_cnt_reg              <= 4'h0;
      prox_irq_reg             <= 1'b0;
      prox_saturation_flag_reg <= 1'b0;
      valid_reg                <= 1'b0;
    end
    else if (ce)
    begin
      if (eval)
      begin
        data_reg    <= result_w;
        out_cnt_reg <= !outside_w ? 4'h0 : (cnt_inc[4] ? 4'hf : cnt_inc[3:0]);
      end
      prox_irq_reg <= fire || (prox_irq_reg && !clr_cmd);
      prox_saturation_flag_reg <= sat_evt || (prox_saturation_flag_reg && !clr_cmd);
      valid_reg <= ctrl_reg.prox_function_enable && (valid_reg || eval);
    end
  end

  // ==========================================================================
  // sticky events, mask, interrupt line and pins; all outputs from flops
  wire [2:0] ev_set  = {sat_evt, fire, eval};
  wire [2:0] ev_next = ev_set | (ev_reg & ~w1c);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ev_reg              <= 3'b000;
      irq                 <= 1'b0;
      led_sink_driver_pin <= 1'b0;
      led_drive_level     <= 2'b00;
      int_pin_out         <= 1'b0;
      int_pin_oe          <= 1'b0;
    end
    else if (ce)
    begin
      ev_reg              <= ev_next;
      irq                 <= |(ev_next & mask_reg);
      led_sink_driver_pin <= led_on;
      led_drive_level     <= led_reg.led_drive_level;
      int_pin_out         <= 1'b0;
      int_pin_oe          <= prox_irq_reg && ctrl_reg.prox_irq_output_enable;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic [8:0] rise_cnt;
  // burst length taken at idle and counted down per rise, so a mid-burst count write is harmless
  always_ff @(posedge clk)
  begin
    if (sys_rst || (ce && state_reg == ST_IDLE))
      rise_cnt <= {1'b0, led_reg.led_pulse_count};
    else if (ce && led_on && !led_sink_driver_pin)
      rise_cnt <= rise_cnt - 9'h001;
  end

  AST_BURST_COUNT: assert property (ce && conv_go |-> rise_cnt == 9'h000)
    else $error("pulse burst count wrong");
  AST_LED_IN_BURST: assert property (led_sink_driver_pin |-> $past(state_reg) == ST_PULSE)
    else $error("led on outside burst");
  AST_IRQ_HOLD: assert property (ce && prox_irq_reg && !clr_cmd |=> prox_irq_reg)
    else $error("interrupt dropped without clear");
  AST_WINDOW_FIRE: assert property (ce && eval && outside_w && persist_reg <= 4'h1
                                    |=> prox_irq_reg)
    else $error("outside result did not flag");
  AST_INSIDE_RESET: assert property (ce && eval && !outside_w |=> out_cnt_reg == 4'h0)
    else $error("persistence not restarted");
  AST_PIN_GATE: assert property (ce && !(prox_irq_reg && ctrl_reg.prox_irq_output_enable)
                                 |=> !int_pin_oe && !int_pin_out)
    else $error("pin driven while not enabled");
  AST_SAT_STICKY: assert property (ce && prox_saturation_flag_reg && !clr_cmd
                                   |=> prox_saturation_flag_reg)
    else $error("saturation flag lost");
  AST_SLEEP_AFTER: assert property (ce && fire && ctrl_reg.sleep_after_irq
                                    |=> state_reg == ST_SLEEP)
    else $error("no sleep after interrupt");
  AST_NO_POWER: assert property (ce && state_reg == ST_IDLE && !ctrl_reg.power_on_bit
                                 |=> state_reg == ST_SLEEP)
    else $error("idle without power did not sleep");

  COV_BURST: cover property (ce && conv_go && led_reg.led_pulse_count == 8'h02);
  COV_FIRE: cover property (fire);
  COV_WAIT: cover property (state_reg == ST_WAIT ##1 state_reg == ST_IDLE);

endmodule

/* sim/pmi_host_model.sv */
// two-wire bus controller model: start condition, one byte, stop
`timescale 1ns/10ps
module pmi_host_model
  import pmi_pkg::*;
(
  output logic bus_scl,
  output logic bus_sda
);
  // idle: both lines at the pull-up level, clock stands still outside frames
  initial
  begin
    bus_scl = 1'b1;
    bus_sda = 1'b1;
  end

  // 64 ns link clock, phase unrelated to clk since the offset is odd
  task automatic send_frame(input logic [7:0] b);
    int i;
    #29;
    bus_sda = 1'b0; // data falls while clock high
    #32;
    for (i = 7; i >= 0; i--)
    begin
      bus_scl = 1'b0;
      #16 bus_sda = b[i];
      #16 bus_scl = 1'b1;
      #32;
    end
    bus_scl = 1'b0;
    #16 bus_sda = 1'b0;
    #16 bus_scl = 1'b1;
    #16 bus_sda = 1'b1; // stop, lines back to idle
  endtask
endmodule

/* sim/pmi_top_tb_top.sv */
// self-checking bench for the proximity measure and interrupt controller
`timescale 1ns/10ps
module pmi_top_tb_top
  import pmi_pkg::*;
();
  // ==========================================================================
  // stimulus and observed signals
  logic        clk             = 1'b0;
  logic        sys_rst         = 1'b1;
  logic [5:0]  avs_address     = 6'h00;
  logic        avs_read        = 1'b0;
  logic        avs_write       = 1'b0;
  logic [31:0] avs_writedata   = 32'h0000_0000;
  logic [9:0]  afe_step_count  = 10'h064;
  logic        afe_saturated   = 1'b0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic        bus_scl;
  logic        bus_sda;
  logic        led_sink_driver_pin;
  logic [1:0]  led_drive_level;
  logic        int_pin_out;
  logic        int_pin_oe;
  logic        led_q           = 1'b0;
  int          hi_cnt          = 0;
  int          per_cnt         = 0;
  int          hi_len          = 0;
  int          period          = 0;
  int          rises           = 0;
  int          cycles          = 0;
  int          miscompares     = 0;
  int          n_compared      = 0;
  int          r0;
  logic [31:0] v;

  always #2.5 clk = ~clk;

  pmi_host_model host (.bus_scl(bus_scl), .bus_sda(bus_sda));

  // short steps keep conversions and waits to a few tens of cycles
  pmi_top #(.STEP_CYC(20), .WAIT_CYC(20)) uut (
    .clk(clk), .sys_rst(sys_rst), .ce(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .bus_scl(bus_scl), .bus_sda(bus_sda), .afe_step_count(afe_step_count),
    .afe_saturated(afe_saturated), .led_sink_driver_pin(led_sink_driver_pin),
    .led_drive_level(led_drive_level), .int_pin_out(int_pin_out),
    .int_pin_oe(int_pin_oe));

  // led monitor: high width, rise-to-rise period and rise count
  always @(posedge clk)
  begin
    led_q <= led_sink_driver_pin;
    hi_cnt <= (led_sink_driver_pin === 1'b1) ? hi_cnt + 1 : 0;
    per_cnt <= (led_sink_driver_pin && !led_q) ? 1 : per_cnt + 1;
    if (led_sink_driver_pin && !led_q)
    begin
      rises <= rises + 1;
      period <= per_cnt;
    end
    if (!led_sink_driver_pin && led_q)
      hi_len <= hi_cnt;
  end

  // a hang counts as a mismatch; the run needs about 54000 cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 80000)
    begin
      miscompares++;
      complete_run();
    end
  end

  // ==========================================================================
  // bus and compare tasks
  task automatic bus_wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  task automatic bus_rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // poll the done event, then clear only that bit
  task automatic wait_done();
    logic [31:0] s;
    s = 32'h0000_0000;
    while (s[EV_DONE] !== 1'b1) bus_rd(OFS_EV_STATUS, s);
    bus_wr(OFS_EV_STATUS, 32'h0000_0001);
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset();
    bus_rd(OFS_CONV_STEP, v);
    chk(v, 32'h0000_00ff);
    bus_rd(OFS_LED_CFG, v);
    chk(v, 32'h0000_0001);
    bus_rd(6'h3c, v);
    chk(v, 32'h0000_0000);
    chk(int_pin_oe, 1'b0);
  endtask

  // two pulses, two steps of 100 plus offset 5, low threshold above result
  task automatic t_measure();
    bus_wr(OFS_LED_CFG, 32'h0000_0202);
    bus_wr(OFS_CONV_STEP, 32'h0000_00fe);
    bus_wr(OFS_OFFSET, 32'h0000_0005);
    bus_wr(OFS_PERSIST, 32'h0000_0002);
    bus_wr(OFS_LOW_THR, 32'h0000_012c);
    bus_wr(OFS_HIGH_THR, 32'h0000_ffff);
    bus_wr(OFS_EV_MASK, 32'h0000_0002);
    bus_wr(OFS_ENABLE, 32'h0000_000b);
    wait_done();
    r0 = rises;
    bus_rd(OFS_DATA, v);
    chk(v, 32'h0000_00cd);
    chk(irq, 1'b0);
    wait_done();
    chk(rises - r0, 2);
    chk(hi_len, 1440);
    chk(led_drive_level, 2'h2);
    chk(irq, 1'b1);
    chk(int_pin_oe, 1'b1);
    chk(int_pin_out, 1'b0);
    // the last rise opened a new burst; its second pulse gives an in-burst period
    r0 = rises;
    while (rises == r0) @(posedge clk);
    @(posedge clk);
    chk(period, 3200);
  endtask

  // output enable off keeps status; clear command drops the interrupt
  task automatic t_irq();
    bus_wr(OFS_LED_CFG, 32'h0000_0201);
    bus_wr(OFS_ENABLE, 32'h0000_0003);
    bus_rd(OFS_STATUS, v);
    chk(v[STAT_IRQ], 1'b1);
    chk(int_pin_oe, 1'b0);
    bus_wr(OFS_LOW_THR, 32'h0000_0000);
    bus_wr(OFS_COMMAND, 32'h0000_0001);
    bus_wr(OFS_EV_STATUS, 32'h0000_0007);
    bus_rd(OFS_STATUS, v);
    chk(v[STAT_IRQ], 1'b0);
    chk(irq, 1'b0);
  endtask

  // low above high ignores high; then a proper window fires on high
  task automatic t_order();
    int i;
    // two wait steps; the sequencer must be seen parked in the wait state
    bus_wr(OFS_WAIT_STEP, 32'h0000_00fe);
    bus_wr(OFS_ENABLE, 32'h0000_0007);
    v = 32'h0000_0000;
    for (i = 0; i < 4000 && v[5:3] !== ST_WAIT; i++)
      bus_rd(OFS_STATUS, v);
    chk(v[5:3], ST_WAIT);
    bus_wr(OFS_PERSIST, 32'h0000_0001);
    bus_wr(OFS_LOW_THR, 32'h0000_0010);
    bus_wr(OFS_HIGH_THR, 32'h0000_0005);
    wait_done();
    wait_done();
    bus_rd(OFS_EV_STATUS, v);
    chk(v[EV_FIRE], 1'b0);
    bus_wr(OFS_LOW_THR, 32'h0000_0001);
    wait_done();
    wait_done();
    bus_rd(OFS_EV_STATUS, v);
    chk(v[EV_FIRE], 1'b1);
  endtask

  // saturation flag is sticky until the clear command
  task automatic t_sat();
    afe_saturated <= 1'b1;
    wait_done();
    wait_done();
    afe_saturated <= 1'b0;
    wait_done();
    bus_rd(OFS_STATUS, v);
    chk(v[STAT_SAT], 1'b1);
    bus_wr(OFS_COMMAND, 32'h0000_0001);
    bus_rd(OFS_STATUS, v);
    chk(v[STAT_SAT], 1'b0);
  endtask

  // sleep after interrupt: no bursts until a bus start wakes the block
  task automatic t_sai();
    int i;
    bus_wr(OFS_ENABLE, 32'h0000_0001);
    // let a measurement already under way finish before clearing its events
    repeat (3500) @(posedge clk);
    bus_wr(OFS_COMMAND, 32'h0000_0001);
    bus_wr(OFS_EV_STATUS, 32'h0000_0007);
    bus_wr(OFS_ENABLE, 32'h0000_0013);
    for (i = 0; i < 8000 && irq !== 1'b1; i++)
      @(posedge clk);
    chk(irq, 1'b1);
    r0 = rises;
    repeat (4000) @(posedge clk);
    chk(rises - r0, 0);
    host.send_frame(8'h72);
    repeat (4000) @(posedge clk);
    chk(rises != r0, 1'b1);
  endtask

  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_measure();
    t_irq();
    t_order();
    t_sat();
    t_sai();
    complete_run();
  end
endmodule
